// [core/rsr_map.svh]
// Timing, sizing and keyboard code constants of the repertory store
`ifndef RSR_MAP_SVH
`define RSR_MAP_SVH
`define RSR_CLK_HZ 25000000
`define RSR_NOM_HZ 18000
`define RSR_TICK_DIV (`RSR_CLK_HZ / `RSR_NOM_HZ)
`define RSR_XFER_MS 60
`define RSR_XFER_TICKS ((`RSR_XFER_MS * `RSR_NOM_HZ + 999) / 1000)
`define RSR_DB_US 4200
`define RSR_DB_TICKS ((`RSR_DB_US * `RSR_NOM_HZ + 999999) / 1000000)
`define RSR_KEY_MS 10
`define RSR_KEY_CYC (`RSR_KEY_MS * (`RSR_CLK_HZ / 1000))
`define RSR_POR_MS 3
`define RSR_POR_CYC (`RSR_POR_MS * (`RSR_CLK_HZ / 1000))
`define RSR_MAX_CHARS 22
`define RSR_LOCATIONS 10
`define RSR_LINES_IDLE 4'hF
`define RSR_K1 4'hF
`define RSR_K2 4'hE
`define RSR_K3 4'hD
`define RSR_K4 4'hB
`define RSR_K5 4'hA
`define RSR_K6 4'h9
`define RSR_K7 4'h7
`define RSR_K8 4'h6
`define RSR_K9 4'h5
`define RSR_K0 4'hC
`define RSR_KPAUSE 4'h3
`define RSR_NO_LOC 4'hF
`endif

// [core/rsr_pkg.sv]
// Types shared by both ends of the repertory store link
package rsr_pkg;
  typedef enum logic [2:0] {
    DEV_IDLE, DEV_RET_ADDR, DEV_RET_WAIT, DEV_RET_ON, DEV_RET_OFF,
    DEV_ST_ADDR, DEV_ST_DIGITS, DEV_DONE
  } rsr_dev_state_t;
  typedef enum logic [2:0] {
    H_POR, H_IDLE, H_SETUP, H_KEY_LO, H_KEY_HI, H_WAIT
  } rsr_host_state_t;
  typedef enum logic [1:0] {
    OP_RETRIEVE, OP_STORE_BEGIN, OP_KEY, OP_STORE_END
  } rsr_op_t;
endpackage

// [core/rsr_if.sv]
// Pin bundle between the store chip and the keypad side controller
interface rsr_if (
  input wire logic clk_sys
);
  logic retrieve;
  logic store_req;
  logic cle;
  logic cs;
  logic por_n;
  logic key_in_n;
  logic [3:0] code_host_o;
  logic code_host_oe_n;
  logic [3:0] code_dev_o;
  logic code_dev_oe_n;
  logic [3:0] code_line;
  logic dig_dis_n;
  logic adr_dis_n;
  logic key_out_n;
  // Code lines are wired-AND with a pull-up: any driver can pull low
  assign code_line = (code_dev_oe_n ? 4'hF : code_dev_o) &
                     (code_host_oe_n ? 4'hF : code_host_o);
  modport dev (
    input retrieve, store_req, cle, cs, por_n, key_in_n, code_line,
    output code_dev_o, code_dev_oe_n, dig_dis_n, adr_dis_n, key_out_n
  );
  modport host (
    input code_line, dig_dis_n, adr_dis_n, key_out_n,
    output retrieve, store_req, cle, cs, por_n, key_in_n,
    output code_host_o, code_host_oe_n
  );
endinterface

// [core/rsr_store.sv]
// Repertory store chip: debounce, number memory and retrieve sequencer
// How it works
// - Retrieve input arms address entry for retrieve
// - Keypad side holds enable and select high
// - Retrieve still high at end repeats retrieve
// - Address latched, both keyboard disables go active
// - First digit follows latch after 60 ms
// - Strobe only while code stable, 60 ms
// - Characters sent 60 ms on, 60 ms off
// - After sending, reset, release, pass strobes through
// - Store plus address without digits erases location
// - Keypad side ends erase by dropping store
// - Debounce all inputs but select, reset
// - Keypad strobe held low at least 10 ms
// - Power-on reset held low at least 3 ms
// - All intervals scale with tick clock rate; keypad strobe and reset holds count clk_sys cycles
// - Keyboard disables drive low while active
// - Code lines rest high, low for data
`include "rsr_map.svh"

module rsr_debounce #(
  parameter int W = 1,
  parameter int DB_TICKS = `RSR_DB_TICKS,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Sampling tick and levels
  input wire logic tick,
  input wire logic [W-1:0] raw,
  output logic [W-1:0] clean
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] clean_reg;
  logic [7:0] cnt_reg;

  generate
    if (DB_TICKS < 1 || DB_TICKS > 255) begin : g_bad
      $error("debounce interval out of range");
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s1_reg <= INIT;
      s2_reg <= INIT;
    end else begin
      s1_reg <= raw;
      s2_reg <= s1_reg;
    end
  end

  // Input is taken once it has differed from the clean level for DB_TICKS ticks
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      clean_reg <= INIT;
      cnt_reg <= 8'h00;
    end else if (s2_reg == clean_reg) begin
      cnt_reg <= 8'h00;
    end else if (tick) begin
      if (cnt_reg == 8'(DB_TICKS - 1)) begin
        clean_reg <= s2_reg;
        cnt_reg <= 8'h00;
      end else begin
        cnt_reg <= cnt_reg + 8'h01;
      end
    end
  end

  assign clean = clean_reg;
endmodule

module rsr_store #(
  parameter int TICK_DIV = `RSR_TICK_DIV,
  parameter int XFER_TICKS = `RSR_XFER_TICKS,
  parameter int DB_TICKS = `RSR_DB_TICKS
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Pins toward keypad side
  rsr_if.dev pins,
  // Status
  output logic busy
);
  localparam int LOCS = `RSR_LOCATIONS;
  localparam int MAXC = `RSR_MAX_CHARS;

  rsr_pkg::rsr_dev_state_t state_reg;
  logic [11:0] div_reg;
  logic tick;
  logic [10:0] tmr_reg;
  logic tmr_end;
  logic cs_s1_reg;
  logic cs_s2_reg;
  logic por_s1_reg;
  logic por_s2_reg;
  logic ctl_rst;
  logic ret_db;
  logic store_db;
  logic cle_db;
  logic key_db;
  logic [3:0] code_db;
  logic key_prev_reg;
  logic press;
  logic [3:0] data;
  logic [3:0] loc;
  logic [3:0] addr_reg;
  logic [4:0] idx_reg;
  logic [4:0] len_reg [0:LOCS-1];
  logic [3:0] mem [0:LOCS-1][0:MAXC-1];
  logic xfer;
  logic [3:0] code_o_reg;
  logic code_oe_n_reg;
  logic dig_dis_n_reg;
  logic adr_dis_n_reg;
  logic key_out_n_reg;

  generate
    if (TICK_DIV < 2 || TICK_DIV > 4095 || XFER_TICKS < 2 ||
        XFER_TICKS > 2047) begin : g_bad
      $error("timing parameters out of range");
    end
  endgenerate

  function automatic logic [3:0] loc_of(input logic [3:0] d);
    case (d)
      `RSR_K1: loc_of = 4'h0;
      `RSR_K2: loc_of = 4'h1;
      `RSR_K3: loc_of = 4'h2;
      `RSR_K4: loc_of = 4'h3;
      `RSR_K5: loc_of = 4'h4;
      `RSR_K6: loc_of = 4'h5;
      `RSR_K7: loc_of = 4'h6;
      `RSR_K8: loc_of = 4'h7;
      `RSR_K9: loc_of = 4'h8;
      `RSR_K0: loc_of = 4'h9;
      default: loc_of = `RSR_NO_LOC;
    endcase
  endfunction

  // Tick at the nominal device clock; every interval counts these
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      div_reg <= 12'h000;
    end else if (div_reg == 12'(TICK_DIV - 1)) begin
      div_reg <= 12'h000;
    end else begin
      div_reg <= div_reg + 12'h001;
    end
  end
  assign tick = (div_reg == 12'(TICK_DIV - 1));

  // Chip select and power-on reset are synchronised but not debounced
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cs_s1_reg <= 1'b0;
      cs_s2_reg <= 1'b0;
      por_s1_reg <= 1'b0;
      por_s2_reg <= 1'b0;
    end else begin
      cs_s1_reg <= pins.cs;
      cs_s2_reg <= cs_s1_reg;
      por_s1_reg <= pins.por_n;
      por_s2_reg <= por_s1_reg;
    end
  end
  assign ctl_rst = !rst_n || !por_s2_reg;

  rsr_debounce #(.W(1), .DB_TICKS(DB_TICKS), .INIT(1'b0)) u_db_ret (
    .clk_sys(clk_sys), .rst_n(rst_n), .tick(tick),
    .raw(pins.retrieve), .clean(ret_db));
  rsr_debounce #(.W(1), .DB_TICKS(DB_TICKS), .INIT(1'b0)) u_db_st (
    .clk_sys(clk_sys), .rst_n(rst_n), .tick(tick),
    .raw(pins.store_req), .clean(store_db));
  rsr_debounce #(.W(1), .DB_TICKS(DB_TICKS), .INIT(1'b0)) u_db_cle (
    .clk_sys(clk_sys), .rst_n(rst_n), .tick(tick),
    .raw(pins.cle), .clean(cle_db));
  rsr_debounce #(.W(1), .DB_TICKS(DB_TICKS), .INIT(1'b1)) u_db_key (
    .clk_sys(clk_sys), .rst_n(rst_n), .tick(tick),
    .raw(pins.key_in_n), .clean(key_db));
  rsr_debounce #(.W(4), .DB_TICKS(DB_TICKS), .INIT(4'hF)) u_db_code (
    .clk_sys(clk_sys), .rst_n(rst_n), .tick(tick),
    .raw(pins.code_line), .clean(code_db));

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      key_prev_reg <= 1'b1;
    end else begin
      key_prev_reg <= key_db;
    end
  end
  // Key closure is a falling edge; ignored while not selected
  assign press = key_prev_reg && !key_db && cs_s2_reg;
  assign data = ~code_db;
  assign loc = loc_of(data);
  assign tmr_end = tick && (tmr_reg == 11'(XFER_TICKS - 1));

  always_ff @(posedge clk_sys) begin
    if (ctl_rst || !cle_db) begin
      state_reg <= rsr_pkg::DEV_IDLE;
      addr_reg <= 4'h0;
      idx_reg <= 5'h00;
      tmr_reg <= 11'h000;
    end else begin
      if (tick) begin
        tmr_reg <= tmr_end ? 11'h000 : tmr_reg + 11'h001;
      end
      case (state_reg)
        rsr_pkg::DEV_IDLE: begin
          if (cs_s2_reg && ret_db) begin
            state_reg <= rsr_pkg::DEV_RET_ADDR;
          end else if (cs_s2_reg && store_db) begin
            state_reg <= rsr_pkg::DEV_ST_ADDR;
          end
        end
        rsr_pkg::DEV_RET_ADDR: begin
          if (press && loc != `RSR_NO_LOC) begin
            addr_reg <= loc;
            idx_reg <= 5'h00;
            tmr_reg <= 11'h000;
            state_reg <= rsr_pkg::DEV_RET_WAIT;
          end
        end
        rsr_pkg::DEV_RET_WAIT: begin
          if (tmr_end) begin
            if (len_reg[addr_reg] == 5'h00) begin
              state_reg <= ret_db ? rsr_pkg::DEV_RET_WAIT
                                  : rsr_pkg::DEV_DONE;
            end else begin
              state_reg <= rsr_pkg::DEV_RET_ON;
            end
          end
        end
        rsr_pkg::DEV_RET_ON: begin
          if (tmr_end) begin
            state_reg <= rsr_pkg::DEV_RET_OFF;
          end
        end
        rsr_pkg::DEV_RET_OFF: begin
          if (tmr_end) begin
            if (idx_reg + 5'h01 == len_reg[addr_reg] ||
                idx_reg == 5'(MAXC - 1)) begin
              idx_reg <= 5'h00;
              state_reg <= ret_db ? rsr_pkg::DEV_RET_WAIT
                                  : rsr_pkg::DEV_DONE;
            end else begin
              idx_reg <= idx_reg + 5'h01;
              state_reg <= rsr_pkg::DEV_RET_ON;
            end
          end
        end
        rsr_pkg::DEV_ST_ADDR: begin
          if (!store_db) begin
            state_reg <= rsr_pkg::DEV_IDLE;
          end else if (press && loc != `RSR_NO_LOC) begin
            addr_reg <= loc;
            state_reg <= rsr_pkg::DEV_ST_DIGITS;
          end
        end
        rsr_pkg::DEV_ST_DIGITS: begin
          if (!store_db) begin
            state_reg <= rsr_pkg::DEV_IDLE;
          end
        end
        rsr_pkg::DEV_DONE: begin
          state_reg <= rsr_pkg::DEV_DONE;
        end
        default: begin
          state_reg <= rsr_pkg::DEV_IDLE;
        end
      endcase
    end
  end

  // Length table: cleared by address latch in store mode, so no digits
  // afterwards leaves the location erased
  always_ff @(posedge clk_sys) begin
    if (ctl_rst) begin
      for (int i = 0; i < LOCS; i++) begin
        len_reg[i] <= 5'h00;
      end
    end else if (cle_db && store_db && press) begin
      if (state_reg == rsr_pkg::DEV_ST_ADDR && loc != `RSR_NO_LOC) begin
        len_reg[loc] <= 5'h00;
      end else if (state_reg == rsr_pkg::DEV_ST_DIGITS &&
                   (loc != `RSR_NO_LOC || data == `RSR_KPAUSE) &&
                   len_reg[addr_reg] != 5'(MAXC)) begin
        len_reg[addr_reg] <= len_reg[addr_reg] + 5'h01;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (cle_db && store_db && press &&
        state_reg == rsr_pkg::DEV_ST_DIGITS &&
        len_reg[addr_reg] != 5'(MAXC)) begin
      mem[addr_reg][len_reg[addr_reg]] <= data;
    end
  end

  assign xfer = state_reg == rsr_pkg::DEV_RET_WAIT ||
                state_reg == rsr_pkg::DEV_RET_ON ||
                state_reg == rsr_pkg::DEV_RET_OFF;

  always_ff @(posedge clk_sys) begin
    if (ctl_rst) begin
      code_o_reg <= `RSR_LINES_IDLE;
      code_oe_n_reg <= 1'b1;
      dig_dis_n_reg <= 1'b1;
      adr_dis_n_reg <= 1'b1;
    end else begin
      dig_dis_n_reg <= !(xfer && cs_s2_reg);
      adr_dis_n_reg <= !((xfer || state_reg == rsr_pkg::DEV_ST_DIGITS)
                         && cs_s2_reg);
      code_oe_n_reg <= !(xfer && cs_s2_reg);
      if (state_reg == rsr_pkg::DEV_RET_ON) begin
        code_o_reg <= ~mem[addr_reg][idx_reg];
      end else begin
        code_o_reg <= `RSR_LINES_IDLE;
      end
    end
  end

  // Strobe routing: replica while disabled or done, generated during transfer, held high otherwise
  always_ff @(posedge clk_sys) begin
    if (ctl_rst) begin
      key_out_n_reg <= 1'b1;
    end else if (!cle_db) begin
      key_out_n_reg <= key_db;
    end else if (!cs_s2_reg) begin
      key_out_n_reg <= 1'b1;
    end else if (state_reg == rsr_pkg::DEV_RET_ON) begin
      key_out_n_reg <= 1'b0;
    end else if (state_reg == rsr_pkg::DEV_DONE) begin
      key_out_n_reg <= key_db;
    end else begin
      key_out_n_reg <= 1'b1;
    end
  end

  assign pins.code_dev_o = code_o_reg;
  assign pins.code_dev_oe_n = code_oe_n_reg;
  assign pins.dig_dis_n = dig_dis_n_reg;
  assign pins.adr_dis_n = adr_dis_n_reg;
  assign pins.key_out_n = key_out_n_reg;
  assign busy = state_reg != rsr_pkg::DEV_IDLE;
endmodule

// [core/rsr_ctrl.sv]
// Keypad side controller: drives the store chip pins, captures replay
`include "rsr_map.svh"

module rsr_ctrl #(
  parameter int KEY_CYC = `RSR_KEY_CYC,
  parameter int POR_CYC = `RSR_POR_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Pins toward the store chip
  rsr_if.host pins,
  // Command port
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire rsr_pkg::rsr_op_t cmd_op,
  input wire logic [3:0] cmd_code,
  // Replayed characters
  output logic rx_valid,
  output logic [3:0] rx_code
);
  rsr_pkg::rsr_host_state_t state_reg;
  rsr_pkg::rsr_op_t op_reg;
  logic [31:0] cnt_reg;
  logic cnt_end;
  logic ret_reg;
  logic store_reg;
  logic cle_reg;
  logic cs_reg;
  logic por_n_reg;
  logic key_n_reg;
  logic [3:0] code_reg;
  logic oe_n_reg;
  logic seen_reg;
  logic [5:0] s1_reg;
  logic [5:0] s2_reg;
  logic kprev_reg;
  logic rx_valid_reg;
  logic [3:0] rx_code_reg;

  generate
    if (KEY_CYC < 1 || POR_CYC < 1) begin : g_bad
      $error("hold counts must be at least one cycle");
    end
  endgenerate

  assign cnt_end = (state_reg == rsr_pkg::H_POR) ?
                   (cnt_reg == 32'(POR_CYC - 1)) :
                   (cnt_reg == 32'(KEY_CYC - 1));

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_reg <= rsr_pkg::H_POR;
      op_reg <= rsr_pkg::OP_KEY;
      cnt_reg <= 32'h00000000;
      ret_reg <= 1'b0;
      store_reg <= 1'b0;
      cle_reg <= 1'b0;
      cs_reg <= 1'b0;
      por_n_reg <= 1'b0;
      key_n_reg <= 1'b1;
      code_reg <= `RSR_LINES_IDLE;
      oe_n_reg <= 1'b1;
      seen_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_end ? 32'h00000000 : cnt_reg + 32'h00000001;
      if (!s2_reg[4]) begin
        seen_reg <= 1'b1;
      end
      case (state_reg)
        rsr_pkg::H_POR: begin
          if (cnt_end) begin
            por_n_reg <= 1'b1;
            state_reg <= rsr_pkg::H_IDLE;
          end
        end
        rsr_pkg::H_IDLE: begin
          cnt_reg <= 32'h00000000;
          if (cmd_valid) begin
            op_reg <= cmd_op;
            seen_reg <= 1'b0;
            case (cmd_op)
              rsr_pkg::OP_RETRIEVE: begin
                ret_reg <= 1'b1;
                cle_reg <= 1'b1;
                cs_reg <= 1'b1;
                code_reg <= ~cmd_code;
                oe_n_reg <= 1'b0;
                state_reg <= rsr_pkg::H_SETUP;
              end
              rsr_pkg::OP_STORE_BEGIN: begin
                store_reg <= 1'b1;
                cle_reg <= 1'b1;
                cs_reg <= 1'b1;
                state_reg <= rsr_pkg::H_SETUP;
              end
              rsr_pkg::OP_KEY: begin
                code_reg <= ~cmd_code;
                oe_n_reg <= 1'b0;
                state_reg <= rsr_pkg::H_SETUP;
              end
              default: begin
                store_reg <= 1'b0;
                cle_reg <= 1'b0;
                cs_reg <= 1'b0;
              end
            endcase
          end
        end
        rsr_pkg::H_SETUP: begin
          if (cnt_end) begin
            if (op_reg == rsr_pkg::OP_STORE_BEGIN) begin
              state_reg <= rsr_pkg::H_IDLE;
            end else begin
              key_n_reg <= 1'b0;
              state_reg <= rsr_pkg::H_KEY_LO;
            end
          end
        end
        rsr_pkg::H_KEY_LO: begin
          if (cnt_end) begin
            key_n_reg <= 1'b1;
            oe_n_reg <= 1'b1;
            code_reg <= `RSR_LINES_IDLE;
            ret_reg <= 1'b0;
            state_reg <= rsr_pkg::H_KEY_HI;
          end
        end
        rsr_pkg::H_KEY_HI: begin
          if (cnt_end) begin
            if (op_reg != rsr_pkg::OP_RETRIEVE) begin
              state_reg <= rsr_pkg::H_IDLE;
            end else if (seen_reg || !s2_reg[4]) begin
              state_reg <= rsr_pkg::H_WAIT;
            end else begin
              cle_reg <= 1'b0;
              cs_reg <= 1'b0;
              state_reg <= rsr_pkg::H_IDLE;
            end
          end
        end
        rsr_pkg::H_WAIT: begin
          cnt_reg <= 32'h00000000;
          if (s2_reg[4]) begin
            cle_reg <= 1'b0;
            cs_reg <= 1'b0;
            state_reg <= rsr_pkg::H_IDLE;
          end
        end
        default: begin
          state_reg <= rsr_pkg::H_IDLE;
        end
      endcase
    end
  end

  // Pin inputs: code[3:0], digit disable, strobe
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s1_reg <= 6'h3F;
      s2_reg <= 6'h3F;
      kprev_reg <= 1'b1;
    end else begin
      s1_reg <= {pins.key_out_n, pins.dig_dis_n, pins.code_line};
      s2_reg <= s1_reg;
      kprev_reg <= s2_reg[5];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rx_valid_reg <= 1'b0;
      rx_code_reg <= 4'h0;
    end else begin
      rx_valid_reg <= kprev_reg && !s2_reg[5] && !s2_reg[4];
      if (kprev_reg && !s2_reg[5]) begin
        rx_code_reg <= ~s2_reg[3:0];
      end
    end
  end

  assign cmd_ready = state_reg == rsr_pkg::H_IDLE;
  assign rx_valid = rx_valid_reg;
  assign rx_code = rx_code_reg;
  assign pins.retrieve = ret_reg;
  assign pins.store_req = store_reg;
  assign pins.cle = cle_reg;
  assign pins.cs = cs_reg;
  assign pins.por_n = por_n_reg;
  assign pins.key_in_n = key_n_reg;
  assign pins.code_host_o = code_reg;
  assign pins.code_host_oe_n = oe_n_reg;
endmodule

// [bench/rsr_props.sv]
// Checker on the link between the keypad controller and the store chip
module rsr_props #(
  parameter int TICK_DIV = 4,
  parameter int XFER_TICKS = 12,
  parameter int DB_TICKS = 2
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Keypad side levels
  input wire logic cle,
  input wire logic store_req,
  input wire logic key_in_n,
  // Store chip side
  input wire logic [3:0] code_dev_o,
  input wire logic code_dev_oe_n,
  input wire logic [3:0] code_line,
  input wire logic dig_dis_n,
  input wire logic adr_dis_n,
  input wire logic key_out_n
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int ON_CYC = TICK_DIV * XFER_TICKS;
  localparam int DB_MIN = (DB_TICKS - 1) * TICK_DIV;
  int on_cnt;
  int off_cnt;
  int kin_lo;
  int chr_cnt;

  // Lengths of strobe on and off phases, key press, characters sent
  always_ff @(posedge clk_sys) begin
    on_cnt <= (!rst_n || key_out_n) ? 0 : on_cnt + 1;
  end
  always_ff @(posedge clk_sys) begin
    off_cnt <= (!rst_n || !key_out_n || dig_dis_n) ? 0 : off_cnt + 1;
  end
  always_ff @(posedge clk_sys) begin
    kin_lo <= (!rst_n || key_in_n) ? 0 : kin_lo + 1;
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n || dig_dis_n)
      chr_cnt <= 0;
    else if ($fell(key_out_n))
      chr_cnt <= chr_cnt + 1;
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  property p_strobe_code;
    !dig_dis_n && !key_out_n && !$past(key_out_n) |->
      !code_dev_oe_n && $stable(code_dev_o);
  endproperty
  a_strobe_code: assert property (p_strobe_code)
    else $error("code moved under strobe");
  property p_on_time;
    $rose(key_out_n) && !dig_dis_n |->
      on_cnt >= ON_CYC && on_cnt <= ON_CYC + TICK_DIV;
  endproperty
  a_on_time: assert property (p_on_time)
    else $error("strobe on time wrong");
  property p_off_time;
    $fell(key_out_n) && !dig_dis_n |->
      off_cnt >= ON_CYC - TICK_DIV && off_cnt <= ON_CYC + TICK_DIV;
  endproperty
  a_off_time: assert property (p_off_time)
    else $error("strobe off time wrong");
  property p_latch;
    $fell(dig_dis_n) |-> $fell(adr_dis_n) && !code_dev_oe_n;
  endproperty
  a_latch: assert property (p_latch)
    else $error("disables not both active");
  property p_rest;
    !dig_dis_n && key_out_n |-> code_dev_o == 4'hF;
  endproperty
  a_rest: assert property (p_rest)
    else $error("code lines not at rest");
  property p_release;
    $rose(dig_dis_n) |-> $rose(adr_dis_n) && key_out_n;
  endproperty
  a_release: assert property (p_release)
    else $error("disables not released together");
  property p_erase;
    store_req && $fell(adr_dis_n) |-> dig_dis_n && key_out_n;
  endproperty
  a_erase: assert property (p_erase)
    else $error("store address started a transfer");
  property p_debounce;
    !cle && $fell(key_out_n) |-> kin_lo >= DB_MIN;
  endproperty
  a_debounce: assert property (p_debounce)
    else $error("key passed before debounce");
  property p_max_chars;
    chr_cnt <= 22;
  endproperty
  a_max_chars: assert property (p_max_chars)
    else $error("too many characters sent");
endmodule

// [bench/rsr_tb.sv]
// Self-checking bench: keypad controller and store chip back to back
`include "rsr_map.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys;
  logic rst_n;
  logic cmd_valid;
  logic cmd_ready;
  rsr_pkg::rsr_op_t cmd_op;
  logic [3:0] cmd_code;
  logic rx_valid;
  logic [3:0] rx_code;
  logic busy;
  logic [3:0] exp_q[$];
  logic [3:0] mem[10][$];
  logic [3:0] keys[10] = '{`RSR_K1, `RSR_K2, `RSR_K3, `RSR_K4, `RSR_K5,
    `RSR_K6, `RSR_K7, `RSR_K8, `RSR_K9, `RSR_K0};
  int bad_count;
  int checks;
  int strobes;

  rsr_if bus (.clk_sys(clk_sys));
  // First digit must come after the address key hold has ended
  rsr_store #(.TICK_DIV(4), .XFER_TICKS(12), .DB_TICKS(2)) i_rsr_store (
    .clk_sys(clk_sys), .rst_n(rst_n), .pins(bus), .busy(busy));
  rsr_ctrl #(.KEY_CYC(40), .POR_CYC(8)) i_rsr_ctrl (
    .clk_sys(clk_sys), .rst_n(rst_n), .pins(bus), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_code(cmd_code),
    .rx_valid(rx_valid), .rx_code(rx_code));
  rsr_props i_props (
    .clk_sys(clk_sys), .rst_n(rst_n), .cle(bus.cle),
    .store_req(bus.store_req), .key_in_n(bus.key_in_n),
    .code_dev_o(bus.code_dev_o), .code_dev_oe_n(bus.code_dev_oe_n),
    .code_line(bus.code_line), .dig_dis_n(bus.dig_dis_n),
    .adr_dis_n(bus.adr_dis_n), .key_out_n(bus.key_out_n));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic cmp(input logic [3:0] got, input logic [3:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (cmd_ready !== 1'b1 && n < 20000);
    if (cmd_ready !== 1'b1) begin
      bad_count++;
      finish_test();
    end
  endtask

  // Request held over the one edge where ready is sampled high
  task automatic send(input rsr_pkg::rsr_op_t op, input logic [3:0] code);
    wait_ready();
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_code <= code;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
  endtask

  // Released levels must outlast the store chip's debounce
  task automatic settle;
    repeat (40) @(posedge clk_sys);
    cmp({3'b000, busy}, 4'h0);
  endtask

  task automatic store(input int loc, input int len);
    logic [3:0] c;
    mem[loc].delete();
    send(rsr_pkg::OP_STORE_BEGIN, 4'h0);
    send(rsr_pkg::OP_KEY, keys[loc]);
    for (int i = 0; i < len; i++) begin
      c = ($urandom_range(10) == 10) ? `RSR_KPAUSE : keys[$urandom_range(9)];
      send(rsr_pkg::OP_KEY, c);
      if (i < `RSR_MAX_CHARS)
        mem[loc].push_back(c);
    end
    send(rsr_pkg::OP_STORE_END, 4'h0);
    settle();
  endtask

  task automatic fetch(input int loc);
    foreach (mem[loc][i])
      exp_q.push_back(mem[loc][i]);
    send(rsr_pkg::OP_RETRIEVE, keys[loc]);
    wait_ready();
    cmp(4'(exp_q.size()), 4'h0);
    cmp({2'b00, bus.dig_dis_n, bus.adr_dis_n}, 4'h3);
    settle();
  endtask

  // Replayed characters against the oldest note
  always @(posedge clk_sys) begin
    if (rx_valid === 1'b1) begin
      if (exp_q.size() == 0)
        cmp(rx_code, 4'hX);
      else
        cmp(rx_code, exp_q.pop_front());
    end
  end

  always @(negedge bus.key_out_n) begin
    if (bus.dig_dis_n === 1'b1)
      strobes++;
  end

  initial begin
    int s0;
    logic [31:0] seed;
    rst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = rsr_pkg::OP_KEY;
    cmd_code = 4'h0;
    bad_count = 0;
    checks = 0;
    strobes = 0;
    seed = $urandom(32'hC91A);
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (int l = 0; l < 10; l++)
      store(l, 1 + $urandom_range(4));
    for (int l = 9; l >= 0; l--)
      fetch(l);
    $display("Test all locations done");
    store(3, 23);
    fetch(3);
    $display("Test long number done");
    store(3, 0);
    fetch(3);
    $display("Test erase done");
    s0 = strobes;
    send(rsr_pkg::OP_KEY, keys[6]);
    wait_ready();
    cmp(4'(strobes - s0), 4'h1);
    cmp({3'b000, bus.key_out_n}, 4'h1);
    $display("Test dial through done");
    finish_test();
  end
endmodule
